// *** bench/sfsw_host.sv ***
// Host serial controller model: frames opcodes and collects returned identification data
`timescale 1ns/10ps
module sfsw_host (
  output logic      spi_sck_o,
  output logic      spi_cs_n_o,
  output logic      spi_si_o,
  input  wire logic spi_so_i,
  input  wire logic spi_so_oe_n_i
);
  logic [15:0] rx_r;    // Data bits taken after the dummies
  logic        drove_r; // Output enable seen active in the data phase
  logic        rel_r;   // Output released right after select rises

  // Idle: select high, clock stopped low
  initial begin
    spi_sck_o = 1'b0;
    spi_cs_n_o = 1'b0;
    spi_si_o = 1'b0;
    rx_r = 16'h0000;
    drove_r = 1'b0;
    rel_r = 1'b0;
    // A clean select rise clears the per-frame link state
    #1;
    spi_cs_n_o = 1'b1;
  end

  // One frame of nbits clocks; the clock runs only inside the frame
  task automatic frame(input logic [7:0] op, input int nbits);
    rx_r = 16'h0000;
    drove_r = 1'b0;
    spi_cs_n_o = 1'b0;
    #8;
    for (int i = 0; i < nbits; i++) begin
      spi_si_o = (i < 8) ? op[7 - i] : ~spi_si_o;
      #7.5;
      spi_sck_o = 1'b1;
      if (i >= 32) begin
        rx_r = {rx_r[14:0], spi_so_i};
        drove_r = drove_r | ~spi_so_oe_n_i;
      end
      #7.5;
      spi_sck_o = 1'b0;
    end
    #8;
    spi_cs_n_o = 1'b1;
    spi_si_o = ~spi_si_o;
    #1;
    rel_r = spi_so_oe_n_i;
    #100;
  endtask : frame
endmodule : sfsw_host

// *** bench/testbench.sv ***
// Self-checking bench of the sleep, wake and identification block
`timescale 1ns/10ps
module testbench;
  import sfsw_pkg::*;
  localparam logic [SFSW_CNT_W-1:0] PWR = 18'h00014;
  localparam logic [7:0]            IDV = 8'h3a; // Arbitrary identification value

  logic        sys_clk_i = 1'b0;
  logic        reset_i   = 1'b0;
  logic        busy      = 1'b0;
  logic [1:0]  susp      = 2'b00;
  logic        sck, cs_n, si, so, so_oe_n, sleep, ready, standby;
  logic        cmd_valid, suspend_req, sfdp_req, soft_reset;
  logic [7:0]  cmd_op;
  logic [15:0] status;
  int          fail_count = 0;
  int          checks = 0;
  int          cmd_cnt = 0;
  int          sfdp_cnt = 0;
  int          susp_cnt = 0;
  int          srst_cnt = 0;

  // System clock, 8 ns
  always #4 sys_clk_i = ~sys_clk_i;

  sfsw_host host (.spi_sck_o(sck), .spi_cs_n_o(cs_n), .spi_si_o(si), .spi_so_i(so), .spi_so_oe_n_i(so_oe_n));

  sfsw_core #(.PWRUP_CYC(PWR), .ID_VALUE(IDV)) dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_si_i(si),
    .write_busy_flag_i(busy), .suspend_flags_i(susp), .spi_so_o(so), .spi_so_oe_n_o(so_oe_n),
    .sleep_o(sleep), .ready_o(ready), .standby_o(standby), .cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op),
    .suspend_req_o(suspend_req), .sfdp_req_o(sfdp_req), .soft_reset_o(soft_reset), .status_init_o(status)
  );

  // Pulse counters
  always @(posedge sys_clk_i) begin
    if (cmd_valid === 1'b1) cmd_cnt++;
    if (sfdp_req === 1'b1) sfdp_cnt++;
    if (suspend_req === 1'b1) susp_cnt++;
    if (soft_reset === 1'b1) srst_cnt++;
  end

  task automatic conclude;
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic check_flag(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : check_flag

  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cycles

  task automatic set_in(input logic b, input logic [1:0] s);
    @(posedge sys_clk_i);
    busy <= b;
    susp <= s;
  endtask : set_in

  task automatic send(input logic [7:0] op, input int nbits);
    host.frame(op, nbits);
    cycles(8);
  endtask : send

  // Bounded wait on the ready flag (rdy=1) or the sleep flag (rdy=0)
  task automatic wait_flag(input bit rdy, input logic val, input int bound);
    int n;
    n = 0;
    while (((rdy ? ready : sleep) !== val) && n < bound) begin
      cycles(1);
      n++;
    end
    if (n >= bound) begin
      fail_count++;
      $display("wrong value wait expected %b seen %b", val, rdy ? ready : sleep);
      conclude();
    end
  endtask : wait_flag

  // Cuts a hang short
  initial begin
    #300us;
    fail_count++;
    $display("wrong value run time expected done seen hung");
    conclude();
  end

  // Main sequence
  initial begin
    reset_i <= 1'b1; // A real rising edge clears the link's frame summary
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    #1;
    check_flag("sleep at power-up", 1'b0, sleep);
    check_word("delivered status", 16'h0200, status);
    check_flag("output released", 1'b1, so_oe_n);
    cycles(int'(PWR) - 4);
    check_flag("ready before delay", 1'b0, ready);
    wait_flag(1'b1, 1'b1, 12);
    check_flag("standby idle", 1'b1, standby);
    send(8'h03, 8);
    check_word("cmd count", 16'h0001, 16'(cmd_cnt));
    check_word("cmd op", {8'h00, 8'h03}, {8'h00, cmd_op});
    check_flag("sleep after other", 1'b0, sleep);
    send(SFSW_OP_SFDP, 8);
    check_word("sfdp count", 16'h0001, 16'(sfdp_cnt));
    check_word("sfdp op", {8'h00, SFSW_OP_SFDP}, {8'h00, cmd_op});
    send(SFSW_OP_SLEEP, 9);
    check_flag("sleep nine bits", 1'b0, sleep);
    set_in(1'b1, 2'b00);
    send(SFSW_OP_SLEEP, 8);
    check_flag("sleep while busy", 1'b0, sleep);
    check_flag("standby while busy", 1'b0, standby);
    // Suspend acceptance over busy and flag combinations
    send(SFSW_OP_SUSPEND, 8);
    check_word("suspend taken", 16'h0001, 16'(susp_cnt));
    for (int k = 1; k < 4; k++) begin
      set_in(k != 3, (k == 3) ? 2'b00 : 2'(k));
      send(SFSW_OP_SUSPEND, 8);
      check_word("suspend refused", 16'h0001, 16'(susp_cnt));
    end
    send(SFSW_OP_WAKE, 48);
    check_word("id repeated", {IDV, IDV}, host.rx_r);
    check_flag("id driven", 1'b1, host.drove_r);
    check_flag("id released", 1'b1, host.rel_r);
    set_in(1'b1, 2'b00);
    send(SFSW_OP_WAKE, 40);
    check_flag("id while busy", 1'b0, host.drove_r);
    set_in(1'b0, 2'b00);
    send(SFSW_OP_SLEEP, 8);
    check_flag("sleep entered", 1'b1, sleep);
    check_flag("standby asleep", 1'b0, standby);
    send(8'h03, 8);
    send(SFSW_OP_SFDP, 8);
    check_word("cmd asleep", 16'h0001, 16'(cmd_cnt));
    check_word("sfdp asleep", 16'h0001, 16'(sfdp_cnt));
    set_in(1'b1, 2'b00);
    send(SFSW_OP_SUSPEND, 8);
    check_word("suspend asleep", 16'h0001, 16'(susp_cnt));
    send(SFSW_OP_WAKE, 8);
    cycles(60);
    check_flag("wake while busy", 1'b1, sleep);
    set_in(1'b0, 2'b00);
    send(SFSW_OP_WAKE, 8);
    check_flag("ready in recovery", 1'b0, ready);
    cycles(100);
    check_flag("sleep in recovery", 1'b1, sleep);
    wait_flag(1'b0, 1'b0, 2400);
    check_flag("ready after wake", 1'b1, ready);
    send(SFSW_OP_SLEEP, 8);
    send(SFSW_OP_WAKE, 40);
    check_word("id asleep", {8'h00, IDV}, {8'h00, host.rx_r[7:0]});
    wait_flag(1'b0, 1'b0, 2490);
    wait_flag(1'b1, 1'b1, 4);
    send(SFSW_OP_SLEEP, 8);
    send(SFSW_OP_RST_EN, 8);
    send(SFSW_OP_RST, 8);
    check_flag("sleep after reset pair", 1'b0, sleep);
    check_word("reset count", 16'h0001, 16'(srst_cnt));
    send(SFSW_OP_RST_EN, 8);
    send(8'h03, 8);
    send(SFSW_OP_RST, 8);
    check_word("reset broken pair", 16'h0001, 16'(srst_cnt));
    check_word("cmd between", 16'h0002, 16'(cmd_cnt));
    send(SFSW_OP_SLEEP, 8);
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    cycles(3);
    @(posedge sys_clk_i);
    reset_i <= 1'b0;
    #1;
    check_flag("sleep after reset", 1'b0, sleep);
    conclude();
  end
endmodule : testbench

// *** core/sfsw_core.sv ***
// Sleep, wake and identification front end of a serial flash command decoder
// Behaviour
// - Only the sleep opcode enters sleep
// - Asleep: ignore all but wake and reset
// - Select high and idle gives plain standby
// - Sleep needs select rise after bit eight
// - Sleep entered within 3 us of rise
// - Sleep refused during write, program, erase
// - Power-up always starts awake
// - Bare wake opcode ends sleep after recovery
// - Both recoveries last at most 20 us
// - ID after opcode, three dummies, MSB first
// - ID repeats until select rises
// - ID read wakes after ID recovery time
// - Wake/ID ignored while write busy
// - Reset enable then reset clears sleep
// - Nothing accepted before 1.8 ms power-up
// - Status starts zero with quad enable set
// - Discoverable parameter opcode requests table read
// - Suspend only when unsuspended and busy
`timescale 1ns/10ps
module sfsw_core
  import sfsw_pkg::*;
#(
  parameter logic [SFSW_CNT_W-1:0] PWRUP_CYC = SFSW_CNT_W'(SFSW_PWRUP_CYC),
  parameter logic [7:0]            ID_VALUE  = SFSW_ID_DEFAULT
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        spi_sck_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_si_i,
  input  wire logic        write_busy_flag_i,
  input  wire logic [1:0]  suspend_flags_i,
  output logic             spi_so_o,
  output logic             spi_so_oe_n_o,
  output logic             sleep_o,
  output logic             ready_o,
  output logic             standby_o,
  output logic             cmd_valid_o,
  output logic [7:0]       cmd_op_o,
  output logic             suspend_req_o,
  output logic             sfdp_req_o,
  output logic             soft_reset_o,
  output logic [15:0]      status_init_o
);

  localparam int A_ENTRY_MAX = SFSW_SLEEP_ENTRY_CYC;

  // Reset value: awake, deselected, counting power-up
  localparam sfsw_sys_t SYS_RST = '{
    cs_s1:       1'b1,
    cs_s2:       1'b1,
    cs_prev:     1'b1,
    st:          SFSW_ST_PWRUP,
    status_init: SFSW_STATUS_INIT,
    default:     '0
  };

  sfsw_sys_t   s_r;
  sfsw_sys_t   s_nxt;
  sfsw_frame_t frame_w;
  logic        frame_end_w;
  logic        go_w;
  logic        busy_w;

  // Exact eight-bit frame carrying the given opcode
  function automatic logic op_is8(input sfsw_frame_t f, input logic [7:0] code);
    op_is8 = (f.op == code) && f.is8;
  endfunction : op_is8

  // Link side logic on the serial clock
  sfsw_link #(
    .ID_VALUE (ID_VALUE)
  ) u_link (
    .spi_sck_i     (spi_sck_i),
    .spi_cs_n_i    (spi_cs_n_i),
    .spi_si_i      (spi_si_i),
    .reset_i       (reset_i),
    .id_allow_i    (s_r.id_allow),
    .frame_o       (frame_w),
    .spi_so_o      (spi_so_o),
    .spi_so_oe_n_o (spi_so_oe_n_o)
  );

  // Frame end on synchronised select rise; fresh only if clocks were seen
  assign busy_w      = write_busy_flag_i;
  assign frame_end_w = s_r.cs_s2 && !s_r.cs_prev;
  assign go_w        = frame_end_w && (s_r.fr_s2.tog != s_r.tog_seen) && (s_r.st == SFSW_ST_READY);

  // Next state: synchronisers, timers and command decode
  always_comb begin
    s_nxt             = s_r;
    s_nxt.cs_s1       = spi_cs_n_i;
    s_nxt.cs_s2       = s_r.cs_s1;
    s_nxt.cs_prev     = s_r.cs_s2;
    s_nxt.fr_s1       = frame_w;
    s_nxt.fr_s2       = s_r.fr_s1;
    s_nxt.cmd_valid   = 1'b0;
    s_nxt.suspend_req = 1'b0;
    s_nxt.sfdp_req    = 1'b0;
    s_nxt.soft_reset  = 1'b0;
    if (frame_end_w) begin
      s_nxt.tog_seen = s_r.fr_s2.tog;
    end

    // Power-up hold and wake recovery timers
    case (s_r.st)
      SFSW_ST_PWRUP: begin
        if (s_r.cnt == PWRUP_CYC - SFSW_CNT_ONE) begin
          s_nxt.st  = SFSW_ST_READY;
          s_nxt.cnt = '0;
        end else begin
          s_nxt.cnt = s_r.cnt + SFSW_CNT_ONE;
        end
      end
      SFSW_ST_RECOVER: begin
        if (s_r.cnt == '0) begin
          s_nxt.st    = SFSW_ST_READY;
          s_nxt.sleep = 1'b0;
        end else begin
          s_nxt.cnt = s_r.cnt - SFSW_CNT_ONE;
        end
      end
      SFSW_ST_READY: begin
        s_nxt.cnt = '0;
      end
      default: begin
        s_nxt.st  = SFSW_ST_PWRUP;
        s_nxt.cnt = '0;
      end
    endcase

    // Command decode at the end of each clocked frame while ready
    if (go_w) begin
      s_nxt.cmd_op    = s_r.fr_s2.op;
      s_nxt.rst_armed = op_is8(s_r.fr_s2, SFSW_OP_RST_EN);
      if (s_r.rst_armed && op_is8(s_r.fr_s2, SFSW_OP_RST)) begin
        s_nxt.sleep      = 1'b0;
        s_nxt.soft_reset = 1'b1;
      end else if (s_r.sleep) begin
        // Asleep: only wake is honoured, and not while busy
        if (s_r.fr_s2.op == SFSW_OP_WAKE && !busy_w) begin
          if (s_r.fr_s2.is8) begin
            s_nxt.st  = SFSW_ST_RECOVER;
            s_nxt.cnt = SFSW_RES1_LOAD;
          end else if (s_r.fr_s2.ge32) begin
            s_nxt.st  = SFSW_ST_RECOVER;
            s_nxt.cnt = SFSW_RES2_LOAD;
          end
        end
      end else begin
        case (s_r.fr_s2.op)
          SFSW_OP_SLEEP: begin
            if (s_r.fr_s2.is8 && !busy_w) begin
              s_nxt.sleep = 1'b1;
            end
          end
          SFSW_OP_SUSPEND: begin
            if (s_r.fr_s2.is8 && busy_w && suspend_flags_i == 2'b00) begin
              s_nxt.suspend_req = 1'b1;
            end
          end
          SFSW_OP_SFDP: begin
            s_nxt.sfdp_req = 1'b1;
          end
          SFSW_OP_WAKE, SFSW_OP_RST_EN, SFSW_OP_RST: begin
            s_nxt.cmd_valid = 1'b0;
          end
          default: begin
            s_nxt.cmd_valid = 1'b1;
          end
        endcase
      end
    end

    // Flags presented as registered outputs
    s_nxt.ready    = (s_nxt.st == SFSW_ST_READY);
    s_nxt.id_allow = s_nxt.ready && !busy_w;
    s_nxt.standby  = s_nxt.cs_s2 && !busy_w && !s_nxt.sleep;
  end

  // State register; reset leaves the device awake
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s_r <= SYS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sleep_o       = s_r.sleep;
  assign ready_o       = s_r.ready;
  assign standby_o     = s_r.standby;
  assign cmd_valid_o   = s_r.cmd_valid;
  assign cmd_op_o      = s_r.cmd_op;
  assign suspend_req_o = s_r.suspend_req;
  assign sfdp_req_o    = s_r.sfdp_req;
  assign soft_reset_o  = s_r.soft_reset;
  assign status_init_o = s_r.status_init;

  // Cycles since reset release, for the power-up check
  logic [SFSW_CNT_W-1:0] a_up_cnt_r;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      a_up_cnt_r <= '0;
    end else if (a_up_cnt_r != '1) begin
      a_up_cnt_r <= a_up_cnt_r + SFSW_CNT_ONE;
    end
  end

  default clocking cb_sys @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_sleep_frame;
    go_w && s_r.fr_s2.op == SFSW_OP_SLEEP;
  endsequence

  sequence s_sleep_ok;
    s_sleep_frame and (s_r.fr_s2.is8 && !busy_w && !sleep_o);
  endsequence

  sequence s_wake_busy;
    go_w && s_r.fr_s2.op == SFSW_OP_WAKE && busy_w;
  endsequence

  sequence s_reset_pair;
    go_w && s_r.rst_armed && s_r.fr_s2.op == SFSW_OP_RST && s_r.fr_s2.is8;
  endsequence

  a_sleep_cause_only: assert property (
    $rose(sleep_o) |-> $past(go_w) && $past(s_r.fr_s2.op) == SFSW_OP_SLEEP)
    else $error("Sleep entered without a sleep command");

  a_sleep_deaf_cmds: assert property (
    sleep_o |=> !cmd_valid_o && !suspend_req_o && !sfdp_req_o)
    else $error("Command forwarded while asleep");

  a_standby_level_map: assert property (
    !$past(reset_i) |-> standby_o == (s_r.cs_s2 && !$past(write_busy_flag_i) && !sleep_o))
    else $error("Standby flag wrong");

  a_sleep_eighth_bit: assert property (
    s_sleep_frame ##0 !s_r.fr_s2.is8 |=> $stable(sleep_o))
    else $error("Sleep taken from a frame not of eight bits");

  a_sleep_entry_time: assert property (
    s_sleep_ok |-> ##[1:A_ENTRY_MAX] sleep_o)
    else $error("Sleep not entered in time");

  a_sleep_busy_reject: assert property (
    s_sleep_frame ##0 (busy_w && !sleep_o) |=> !sleep_o)
    else $error("Sleep accepted while busy");

  a_wake_recover_bound: assert property (
    s_r.st == SFSW_ST_RECOVER |-> s_r.cnt <= SFSW_RES1_LOAD && s_r.cnt <= SFSW_RES2_LOAD && sleep_o)
    else $error("Recovery timer out of range");

  a_wake_clear_cause: assert property (
    $fell(sleep_o) |-> soft_reset_o || (ready_o && $past(s_r.st) == SFSW_ST_RECOVER))
    else $error("Sleep left without wake or reset");

  a_wake_busy_ignore: assert property (
    s_wake_busy |=> $stable(sleep_o) && ready_o)
    else $error("Wake acted on while busy");

  a_soft_reset_pair: assert property (
    s_reset_pair |=> soft_reset_o && !sleep_o)
    else $error("Reset sequence did not clear sleep");

  a_powerup_hold: assert property (
    ready_o |-> a_up_cnt_r >= PWRUP_CYC)
    else $error("Ready before the power-up delay");

  a_suspend_gate: assert property (
    suspend_req_o |-> $past(write_busy_flag_i) && $past(suspend_flags_i) == 2'b00)
    else $error("Suspend passed without busy or while suspended");

endmodule : sfsw_core

// *** core/sfsw_link.sv ***
// Serial clock side: opcode capture, frame summary and identification shifter
`timescale 1ns/10ps
module sfsw_link
  import sfsw_pkg::*;
#(
  parameter logic [7:0] ID_VALUE = SFSW_ID_DEFAULT
) (
  input  wire logic  spi_sck_i,
  input  wire logic  spi_cs_n_i,
  input  wire logic  spi_si_i,
  input  wire logic  reset_i,
  input  wire logic  id_allow_i,
  output sfsw_frame_t frame_o,
  output logic       spi_so_o,
  output logic       spi_so_oe_n_o
);

  localparam sfsw_lout_t LOUT_IDLE = '{active: 1'b0, so: 1'b0, oe_n: 1'b1, sh: 8'h00};

  sfsw_lctl_t  ctl_r;
  sfsw_lctl_t  ctl_nxt;
  sfsw_frame_t cap_r;
  sfsw_frame_t cap_nxt;
  sfsw_lout_t  out_r;
  sfsw_lout_t  out_nxt;

  // Bit counting, opcode capture and ID shifting
  always_comb begin
    ctl_nxt       = ctl_r;
    cap_nxt       = cap_r;
    out_nxt       = out_r;
    ctl_nxt.id_s1 = id_allow_i;
    ctl_nxt.id_s2 = ctl_r.id_s1;
    ctl_nxt.sh    = {ctl_r.sh[5:0], spi_si_i};
    if (ctl_r.cnt != SFSW_CNT_MAX) begin
      ctl_nxt.cnt = ctl_r.cnt + 6'h01;
    end
    // First edge of a frame flips the toggle so empty frames are ignored
    if (ctl_r.cnt == 6'h00) begin
      cap_nxt.tog = ~cap_r.tog;
    end
    if (ctl_r.cnt == SFSW_OP_BITS - 6'h01) begin
      cap_nxt.op = {ctl_r.sh, spi_si_i};
    end
    cap_nxt.is8  = (ctl_nxt.cnt == SFSW_OP_BITS);
    cap_nxt.ge32 = (ctl_nxt.cnt >= SFSW_ID_START);
    // ID after opcode and three dummies, MSB first, repeating
    if (out_r.active) begin
      out_nxt.so = out_r.sh[7];
      out_nxt.sh = {out_r.sh[6:0], out_r.sh[7]};
    end else if (ctl_r.cnt == SFSW_ID_START && cap_r.op == SFSW_OP_WAKE && ctl_r.id_s2) begin
      out_nxt.active = 1'b1;
      out_nxt.oe_n   = 1'b0;
      out_nxt.so     = ID_VALUE[7];
      out_nxt.sh     = {ID_VALUE[6:0], ID_VALUE[7]};
    end
  end

  // Per-frame state, cleared while deselected
  always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      ctl_r <= '0;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // Frame summary, held stable across the select rise
  always_ff @(posedge spi_sck_i or posedge reset_i) begin
    if (reset_i) begin
      cap_r <= '0;
    end else begin
      cap_r <= cap_nxt;
    end
  end

  // Output changes on falling edges; select high releases the line
  always_ff @(negedge spi_sck_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      out_r <= LOUT_IDLE;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign frame_o       = cap_r;
  assign spi_so_o      = out_r.so;
  assign spi_so_oe_n_o = out_r.oe_n;

  property p_id_start;
    @(negedge spi_sck_i) disable iff (spi_cs_n_i)
    $rose(out_r.active) |-> (spi_so_o == ID_VALUE[7]) && !spi_so_oe_n_o;
  endproperty
  a_id_msb_first: assert property (p_id_start) else $error("ID does not start with its top bit");

  property p_id_repeat;
    @(negedge spi_sck_i) disable iff (spi_cs_n_i)
    out_r.active ##8 out_r.active |-> spi_so_o == $past(spi_so_o, 8);
  endproperty
  a_id_byte_repeat: assert property (p_id_repeat) else $error("ID byte does not repeat");

endmodule : sfsw_link

// *** core/sfsw_pkg.sv ***
// Opcodes, timing counts, reset values and carrier types of the sleep/wake/ID block
package sfsw_pkg;

  // Opcodes handled by this block
  localparam logic [7:0] SFSW_OP_SLEEP   = 8'hb9;
  localparam logic [7:0] SFSW_OP_WAKE    = 8'hab;
  localparam logic [7:0] SFSW_OP_RST_EN  = 8'h66;
  localparam logic [7:0] SFSW_OP_RST     = 8'h99;
  localparam logic [7:0] SFSW_OP_SUSPEND = 8'h75;
  localparam logic [7:0] SFSW_OP_SFDP    = 8'h5a;

  // Bit counts within a frame
  localparam logic [5:0] SFSW_OP_BITS  = 6'h08;
  localparam logic [5:0] SFSW_ID_START = 6'h20;
  localparam logic [5:0] SFSW_CNT_MAX  = 6'h3f;

  // Timing: system clock rate and documented times
  localparam int SFSW_CLK_MHZ        = 125;
  localparam int SFSW_SLEEP_ENTRY_NS = 3000;
  localparam int SFSW_RES1_NS        = 20000;
  localparam int SFSW_RES2_NS        = 20000;
  localparam int SFSW_PWRUP_NS       = 1800000;
  localparam int SFSW_SYNC_LAT       = 4;

  // Longest times round down, least times round up
  localparam int SFSW_SLEEP_ENTRY_CYC = (SFSW_SLEEP_ENTRY_NS * SFSW_CLK_MHZ) / 1000;
  localparam int SFSW_RES1_CYC        = (SFSW_RES1_NS * SFSW_CLK_MHZ) / 1000;
  localparam int SFSW_RES2_CYC        = (SFSW_RES2_NS * SFSW_CLK_MHZ) / 1000;
  localparam int SFSW_PWRUP_CYC       = (SFSW_PWRUP_NS * SFSW_CLK_MHZ + 999) / 1000;

  // Timer width and recovery loads, less the select synchroniser latency
  localparam int                  SFSW_CNT_W     = 18;
  localparam logic [SFSW_CNT_W-1:0] SFSW_CNT_ONE   = 18'h00001;
  localparam logic [SFSW_CNT_W-1:0] SFSW_RES1_LOAD = SFSW_CNT_W'(SFSW_RES1_CYC - SFSW_SYNC_LAT);
  localparam logic [SFSW_CNT_W-1:0] SFSW_RES2_LOAD = SFSW_CNT_W'(SFSW_RES2_CYC - SFSW_SYNC_LAT);

  // Status contents as delivered: only the quad enable bit set
  localparam int          SFSW_QE_POS      = 9;
  localparam logic [15:0] SFSW_STATUS_INIT = 16'h0001 << SFSW_QE_POS;

  // Identification byte, value arbitrary
  localparam logic [7:0] SFSW_ID_DEFAULT = 8'h5c;

  typedef enum logic [1:0] {SFSW_ST_PWRUP, SFSW_ST_READY, SFSW_ST_RECOVER} sfsw_state_t;

  // Frame summary handed from the serial clock domain
  typedef struct packed {
    logic [7:0] op;
    logic       is8;
    logic       ge32;
    logic       tog;
  } sfsw_frame_t;

  // Serial clock domain, cleared by select high
  typedef struct packed {
    logic [5:0] cnt;
    logic [6:0] sh;
    logic       id_s1;
    logic       id_s2;
  } sfsw_lctl_t;

  // Falling edge output shifter
  typedef struct packed {
    logic       active;
    logic       so;
    logic       oe_n;
    logic [7:0] sh;
  } sfsw_lout_t;

  // System clock domain state
  typedef struct packed {
    logic                  cs_s1;
    logic                  cs_s2;
    logic                  cs_prev;
    sfsw_frame_t           fr_s1;
    sfsw_frame_t           fr_s2;
    logic                  tog_seen;
    sfsw_state_t           st;
    logic [SFSW_CNT_W-1:0] cnt;
    logic                  sleep;
    logic                  rst_armed;
    logic                  id_allow;
    logic                  ready;
    logic                  standby;
    logic                  cmd_valid;
    logic [7:0]            cmd_op;
    logic                  suspend_req;
    logic                  sfdp_req;
    logic                  soft_reset;
    logic [15:0]           status_init;
  } sfsw_sys_t;

endpackage : sfsw_pkg
